// ---- hw/flash_prefetch_line_buffer.sv ----
// four-line prefetch buffer between system read port and 128-bit flash array
`timescale 1ns/100ps
module flash_prefetch_line_buffer #(
  parameter int PAGE_LSB = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system read port
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  input wire logic [1:0] rd_type,
  output logic rd_ack,
  output logic [31:0] rd_data,
  output logic rd_err,
  // flash array
  output logic fl_rd_en,
  output logic [27:0] fl_line_addr,
  input wire logic [127:0] fl_rdata,
  input wire logic fl_sec,
  input wire logic fl_ded,
  // flash programming
  input wire logic prog_event,
  input wire logic prog_busy,
  input wire logic [31:0] prog_addr,
  // power
  input wire logic idle_mode,
  input wire logic sleep_mode,
  output logic clk_enable,
  // interrupt
  output logic sec_irq
);

  localparam int TW = flash_prefetch_pkg::TAG_W;
  localparam int LB = flash_prefetch_pkg::LINE_BITS;
  localparam int NL = flash_prefetch_pkg::NUM_LINES;

  // registers
  logic [31:0] ctrl_q;
  logic [31:0] stat_q;
  logic [31:0] stat_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // line arrays
  logic [TW-1:0] tag_q [NL];
  logic [LB-1:0] data_q [NL];
  logic [NL-1:0] valid_q;
  logic [NL-1:0] ded_q;
  logic periph_ptr_q;

  // prediction buffer
  logic pb_valid_q;
  logic [TW-1:0] pb_tag_q;
  logic [LB-1:0] pb_data_q;
  logic pb_sec_q;
  logic pb_ded_q;

  // flash engine
  logic fl_busy_q;
  logic fl_pred_q;
  logic [2:0] fl_cnt_q;
  logic [2:0] fl_ws_q;
  logic [TW-1:0] fl_tag_q;
  logic fl_rd_en_q;

  flash_prefetch_pkg::state_t state_q;
  logic inv_pend_q;
  logic rd_ack_q;
  logic [31:0] rd_data_q;
  logic rd_err_q;
  logic clk_en_q;
  logic sec_irq_q;

  // decode
  logic [2:0] wait_sel;
  logic [1:0] pred_sel;
  logic [TW-1:0] req_tag;
  logic [1:0] req_word;
  logic [NL-1:0] hit_vec;
  logic [1:0] hit_idx;
  logic page_stall;
  logic can_take;
  logic take_hit;
  logic take_pb;
  logic start_dem;
  logic dem_done;
  logic fl_done;
  logic pred_start;
  logic fill_now;
  logic [1:0] fill_idx;
  logic do_inv;
  logic ev_sec;
  logic ev_ded;
  logic [31:0] deliver_word;
  logic deliver_err;
  logic ctrl_wr;
  logic stat_wr;
  logic reg_mapped;

  function automatic logic [31:0] apply_alias(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] kind);
    case (kind)
      flash_prefetch_pkg::ALIAS_CLR: apply_alias = old & ~wd;
      flash_prefetch_pkg::ALIAS_SET: apply_alias = old | wd;
      flash_prefetch_pkg::ALIAS_INV: apply_alias = old ^ wd;
      default: apply_alias = wd;
    endcase
  endfunction

  // which request types may start a predictive fetch
  function automatic logic pred_ok(input logic [1:0] sel, input logic [1:0] typ);
    case (typ)
      flash_prefetch_pkg::TYPE_INSTR: pred_ok = (sel != flash_prefetch_pkg::PRED_OFF);
      flash_prefetch_pkg::TYPE_DATA: pred_ok = (sel >= flash_prefetch_pkg::PRED_CPU);
      default: pred_ok = (sel == flash_prefetch_pkg::PRED_ALL);
    endcase
  endfunction

  // which fill types own a line under the current setting
  function automatic logic fill_ok(input logic [1:0] sel, input logic [1:0] typ);
    case (typ)
      flash_prefetch_pkg::TYPE_INSTR: fill_ok = 1'b1;
      flash_prefetch_pkg::TYPE_DATA: fill_ok = (sel >= flash_prefetch_pkg::PRED_CPU);
      default: fill_ok = (sel == flash_prefetch_pkg::PRED_ALL);
    endcase
  endfunction

  function automatic logic [31:0] word_of(input logic [LB-1:0] line, input logic [1:0] sel);
    word_of = line[sel*flash_prefetch_pkg::WORD_BITS +: flash_prefetch_pkg::WORD_BITS];
  endfunction

  assign wait_sel = ctrl_q[flash_prefetch_pkg::WAIT_LSB +: flash_prefetch_pkg::WAIT_W]; // (R24)
  assign pred_sel = ctrl_q[flash_prefetch_pkg::PRED_LSB +: flash_prefetch_pkg::PRED_W]; // (R23)
  assign req_tag = rd_addr[31:flash_prefetch_pkg::TAG_LSB]; // (R26)
  assign req_word = rd_addr[flash_prefetch_pkg::TAG_LSB-1:flash_prefetch_pkg::WORD_SEL_LSB];

  // address-only compare, type is never looked at
  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_hit
      assign hit_vec[gi] = valid_q[gi] && (tag_q[gi] == req_tag); // (R5)
    end
  endgenerate

  always_comb begin
    hit_idx = 2'h0;
    for (int i = NL - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_idx = 2'(i);
      end
    end
  end

  // request arbitration
  assign page_stall = prog_busy &&
                      (rd_addr[31:PAGE_LSB] == prog_addr[31:PAGE_LSB]); // (R12)
  assign can_take = (state_q == flash_prefetch_pkg::st_idle) && rd_req && !rd_ack_q &&
                    !inv_pend_q && !sleep_mode && !page_stall;
  assign take_hit = can_take && (|hit_vec); // (R1)
  assign take_pb = can_take && !(|hit_vec) && pb_valid_q && (pb_tag_q == req_tag); // (R7)
  // a busy engine is never aborted; the miss waits for it
  assign start_dem = can_take && !(|hit_vec) && !(pb_valid_q && (pb_tag_q == req_tag)) &&
                     !fl_busy_q; // (R9)
  assign fl_done = fl_busy_q && (fl_cnt_q == fl_ws_q); // (R1)
  assign dem_done = (state_q == flash_prefetch_pkg::st_fetch) && fl_done && !fl_pred_q;
  assign fill_now = (take_pb || dem_done) && fill_ok(pred_sel, rd_type); // (R4)
  assign pred_start = (take_pb || dem_done) && pred_ok(pred_sel, rd_type) &&
                      !inv_pend_q && (dem_done || !fl_busy_q); // (R8) (R10)
  assign do_inv = inv_pend_q && (state_q == flash_prefetch_pkg::st_idle) && !fl_busy_q; // (R11)

  always_comb begin
    case (rd_type)
      flash_prefetch_pkg::TYPE_INSTR: fill_idx = flash_prefetch_pkg::LINE_INSTR;
      flash_prefetch_pkg::TYPE_DATA: fill_idx = flash_prefetch_pkg::LINE_DATA;
      default: fill_idx = flash_prefetch_pkg::LINE_PERIPH | {1'b0, periph_ptr_q}; // (R27)
    endcase
  end

  // what goes back to the initiator and which ecc events it carries
  always_comb begin
    deliver_word = 32'h0000_0000;
    deliver_err = 1'b0;
    ev_sec = 1'b0;
    ev_ded = 1'b0;
    if (take_hit) begin
      deliver_word = word_of(data_q[hit_idx], req_word);
      deliver_err = ded_q[hit_idx]; // (R19)
      ev_ded = ded_q[hit_idx];
    end else if (take_pb) begin
      deliver_word = word_of(pb_data_q, req_word);
      deliver_err = pb_ded_q; // (R20)
      ev_sec = pb_sec_q;
      ev_ded = pb_ded_q;
    end else if (dem_done) begin
      deliver_word = word_of(fl_rdata, req_word); // (R2)
      deliver_err = fl_ded; // (R14)
      ev_sec = fl_sec;
      ev_ded = fl_ded;
    end
  end

  // apb decode, aliases sit at +4, +8, +c of each base
  assign reg_mapped = (paddr[1:0] == 2'h0) &&
                      ((paddr[11:4] == flash_prefetch_pkg::CTRL_OFF[11:4]) ||
                       (paddr[11:4] == flash_prefetch_pkg::STAT_OFF[11:4]));
  assign ctrl_wr = psel && penable && pwrite && (paddr[1:0] == 2'h0) &&
                   (paddr[11:4] == flash_prefetch_pkg::CTRL_OFF[11:4]);
  assign stat_wr = psel && penable && pwrite && (paddr[1:0] == 2'h0) &&
                   (paddr[11:4] == flash_prefetch_pkg::STAT_OFF[11:4]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= flash_prefetch_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= apply_alias(ctrl_q, pwdata, paddr[3:0]) & flash_prefetch_pkg::CTRL_MASK; // (R25)
    end
  end

  // hardware sets win over a software clear in the same cycle
  always_comb begin
    stat_d = stat_q;
    if (stat_wr) begin
      stat_d = apply_alias(stat_q, pwdata, paddr[3:0]) & flash_prefetch_pkg::STAT_MASK; // (R25)
      // software may only clear the double-error flag
      stat_d[flash_prefetch_pkg::DED_BIT] = stat_q[flash_prefetch_pkg::DED_BIT] &
                                            stat_d[flash_prefetch_pkg::DED_BIT]; // (R15)
    end else if (ev_sec &&
                 (stat_q[flash_prefetch_pkg::CNT_LSB +: flash_prefetch_pkg::CNT_W] != 8'h00)) begin
      stat_d[flash_prefetch_pkg::CNT_LSB +: flash_prefetch_pkg::CNT_W] =
        stat_q[flash_prefetch_pkg::CNT_LSB +: flash_prefetch_pkg::CNT_W] - 8'h01; // (R16)
    end
    if (ev_sec && (stat_q[flash_prefetch_pkg::CNT_LSB +: flash_prefetch_pkg::CNT_W] == 8'h00)) begin
      stat_d[flash_prefetch_pkg::SECF_BIT] = 1'b1; // (R17)
    end
    if (ev_ded) begin
      stat_d[flash_prefetch_pkg::DED_BIT] = 1'b1; // (R14) (R15)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= flash_prefetch_pkg::STAT_RESET;
    end else begin
      stat_q <= stat_d;
    end
  end

  // apb answers in the access cycle, never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (psel && !penable) begin
        pslverr_q <= !reg_mapped;
        if (!reg_mapped) begin
          prdata_q <= 32'h0000_0000;
        end else if (paddr[11:4] == flash_prefetch_pkg::CTRL_OFF[11:4]) begin
          prdata_q <= ctrl_q;
        end else begin
          prdata_q <= stat_q;
        end
      end
    end
  end

  // flash engine, one access at a time, each runs to the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_busy_q <= 1'b0;
      fl_pred_q <= 1'b0;
      fl_cnt_q <= 3'h0;
      fl_ws_q <= 3'h0;
      fl_tag_q <= '0;
      fl_rd_en_q <= 1'b0;
    end else begin
      fl_rd_en_q <= start_dem || pred_start;
      if (start_dem || pred_start) begin
        fl_busy_q <= 1'b1;
        fl_pred_q <= pred_start;
        fl_cnt_q <= 3'h0;
        fl_ws_q <= wait_sel; // (R1)
        fl_tag_q <= pred_start ? (req_tag + 28'h1) : req_tag; // (R8)
      end else if (fl_done) begin
        fl_busy_q <= 1'b0; // (R9)
      end else if (fl_busy_q) begin
        fl_cnt_q <= fl_cnt_q + 3'h1;
      end
    end
  end

  // request state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= flash_prefetch_pkg::st_idle;
    end else begin
      case (state_q)
        flash_prefetch_pkg::st_idle: begin
          if (start_dem) begin
            state_q <= flash_prefetch_pkg::st_fetch;
          end
        end
        flash_prefetch_pkg::st_fetch: begin
          if (dem_done) begin
            state_q <= flash_prefetch_pkg::st_idle;
          end
        end
        default: state_q <= flash_prefetch_pkg::st_idle;
      endcase
    end
  end

  // line arrays; no preload, mask or lock paths exist (R6)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= '0; // (R13)
      ded_q <= '0;
      periph_ptr_q <= 1'b0;
      for (int i = 0; i < NL; i++) begin
        tag_q[i] <= '0; // (R13)
        data_q[i] <= '0;
      end
    end else if (do_inv) begin
      valid_q <= '0; // (R11)
    end else if (fill_now) begin
      valid_q[fill_idx] <= 1'b1; // (R21)
      tag_q[fill_idx] <= req_tag;
      // corrected data is kept, the sec mark is not
      data_q[fill_idx] <= take_pb ? pb_data_q : fl_rdata; // (R2) (R19)
      ded_q[fill_idx] <= take_pb ? pb_ded_q : fl_ded; // (R21)
      if (rd_type != flash_prefetch_pkg::TYPE_INSTR && rd_type != flash_prefetch_pkg::TYPE_DATA) begin
        periph_ptr_q <= !periph_ptr_q; // (R27)
      end
    end
  end

  // prediction buffer keeps ecc marks until its data is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_valid_q <= 1'b0;
      pb_tag_q <= '0;
      pb_data_q <= '0;
      pb_sec_q <= 1'b0;
      pb_ded_q <= 1'b0;
    end else if (do_inv || pred_start || take_pb) begin
      pb_valid_q <= 1'b0; // (R11)
    end else if (fl_done && fl_pred_q) begin
      pb_valid_q <= 1'b1; // (R3)
      pb_tag_q <= fl_tag_q;
      pb_data_q <= fl_rdata;
      pb_sec_q <= fl_sec; // (R20)
      pb_ded_q <= fl_ded;
    end
  end

  // a new event in the cycle of the flush stays pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inv_pend_q <= 1'b0;
    end else begin
      inv_pend_q <= (inv_pend_q && !do_inv) || prog_event; // (R11)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ack_q <= 1'b0;
      rd_data_q <= 32'h0000_0000;
      rd_err_q <= 1'b0;
    end else begin
      rd_ack_q <= take_hit || take_pb || dem_done; // (R1) (R7)
      rd_data_q <= deliver_word;
      rd_err_q <= deliver_err; // (R14)
    end
  end

  // gate request for an external clock gate; this flop sits on the free clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_q <= 1'b1;
    end else begin
      clk_en_q <= !(sleep_mode || (idle_mode && !fl_busy_q &&
                    (state_q == flash_prefetch_pkg::st_idle))); // (R22)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_irq_q <= 1'b0;
    end else begin
      sec_irq_q <= ctrl_q[flash_prefetch_pkg::SECEN_BIT] &&
                   stat_q[flash_prefetch_pkg::SECF_BIT]; // (R18)
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rd_ack = rd_ack_q;
  assign rd_data = rd_data_q;
  assign rd_err = rd_err_q;
  assign fl_rd_en = fl_rd_en_q;
  assign fl_line_addr = fl_tag_q;
  assign clk_enable = clk_en_q;
  assign sec_irq = sec_irq_q;

endmodule

// ---- hw/flash_prefetch_pkg.sv ----
// constants, register map and field layout of the flash prefetch line buffer
// Operation
// (R1) miss waits flash_wait_cycles clocks before using flash data; hit answers without waits
// (R2) each line holds 128 flash bits from one access, returned as 32-bit words
// (R3) linear fetch with prediction waits only on the first word of each line
// (R4) one instruction line, one cpu data line, two peripheral lines; setting enables types
// (R5) hit compares address only, any read type may hit any valid line
// (R6) no preloading, no address masking, no line locking
// (R7) miss matching prediction moves buffer into a line and returns the word together
// (R8) prediction starts at first read; after a fill fetch the next 16-byte line
// (R9) flash accesses never abort; a new miss waits for the running access
// (R10) only request types allowed by predict_enable_sel start a predictive fetch
// (R11) programming event invalidates lines and prediction buffer after any running transaction
// (R12) read of a page under program or erase stalls until it finishes
// (R13) reset invalidates every line and clears all tag bits
// (R14) double-bit error returns bus error and sets double_error_flag, status bit 27
// (R15) only hardware sets double_error_flag; only software clears it in its handler
// (R16) each corrected read decrements single_error_countdown, holding at zero, never reloading
// (R17) corrected error while countdown is zero sets single_error_flag, status bit 26
// (R18) interrupt stands while sec_irq_enable and single_error_flag are both set
// (R19) line keeps corrected data; later hits on it raise no ecc event
// (R20) ecc errors of predictive fetches are kept and reported only when delivered
// (R21) double-error data is still loaded and the line stays valid until replaced
// (R22) idle lets a running prefetch finish before gating clock; sleep stops clock
// (R23) predict_enable_sel: 11 any, 10 cpu instr and data, 01 instr only, 00 off
// (R24) flash_wait_cycles is a plain binary count from zero to seven
// (R25) clear, set and invert aliases at byte offsets 0x4, 0x8 and 0xc
// (R26) tags hold physical address bits 31 down to 4
// (R27) peripheral fills replace the older peripheral line by an alternating pointer
package flash_prefetch_pkg;
  localparam int NUM_LINES = 4;
  localparam int LINE_BITS = 128;
  localparam int WORD_BITS = 32;
  localparam int TAG_LSB = 4;
  localparam int TAG_W = 28;
  localparam int WORD_SEL_LSB = 2;
  // register map, byte addresses
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h010;
  localparam logic [3:0] ALIAS_CLR = 4'h4;
  localparam logic [3:0] ALIAS_SET = 4'h8;
  localparam logic [3:0] ALIAS_INV = 4'hc;
  // buffer_control_reg fields
  localparam int WAIT_LSB = 0;
  localparam int WAIT_W = 3;
  localparam int PRED_LSB = 4;
  localparam int PRED_W = 2;
  localparam int SECEN_BIT = 26;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
  localparam logic [31:0] CTRL_MASK = 32'h0400_0037;
  // flash_error_status fields
  localparam int DED_BIT = 27;
  localparam int SECF_BIT = 26;
  localparam int CNT_LSB = 0;
  localparam int CNT_W = 8;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  localparam logic [31:0] STAT_MASK = 32'h0c00_00ff;
  // predict_enable_sel codes
  localparam logic [1:0] PRED_OFF = 2'h0;
  localparam logic [1:0] PRED_INSTR = 2'h1;
  localparam logic [1:0] PRED_CPU = 2'h2;
  localparam logic [1:0] PRED_ALL = 2'h3;
  // request types
  localparam logic [1:0] TYPE_INSTR = 2'h0;
  localparam logic [1:0] TYPE_DATA = 2'h1;
  localparam logic [1:0] TYPE_PERIPH = 2'h2;
  // line slots
  localparam logic [1:0] LINE_INSTR = 2'h0;
  localparam logic [1:0] LINE_DATA = 2'h1;
  localparam logic [1:0] LINE_PERIPH = 2'h2;
  typedef enum logic {st_idle, st_fetch} state_t;
endpackage

// ---- verification/flash_array_model.sv ----
// flash array model with a wait-state valid window
`timescale 1ns/100ps
module flash_array_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // access from the buffer
  input wire logic fl_rd_en,
  input wire logic [27:0] fl_line_addr,
  output logic [127:0] fl_rdata,
  output logic fl_sec,
  output logic fl_ded,
  // bench control
  input wire logic [2:0] ws,
  input wire logic [27:0] err_line,
  input wire logic err_sec,
  input wire logic err_ded
);
  logic [2:0] age_q;
  logic [127:0] good;
  logic ok;
  // age saturates so a long-idle array reads as settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 3'h0;
    end else if (fl_rd_en) begin
      age_q <= 3'h1;
    end else if (age_q != 3'h0 && age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  always_comb begin
    ok = (fl_rd_en ? 3'h0 : age_q) >= ws;
    for (int k = 0; k < 4; k++) begin
      good[32*k +: 32] = {fl_line_addr, 2'(k), 2'h3};
    end
    // unsettled array shows inverted data, never a lucky match
    fl_rdata = ok ? good : ~good;
    fl_sec = ok && err_sec && fl_line_addr == err_line;
    fl_ded = ok && err_ded && fl_line_addr == err_line;
  end
endmodule

// ---- verification/flash_prefetch_line_buffer_checker.sv ----
// port checker for the flash prefetch line buffer
`timescale 1ns/100ps
module flash_prefetch_line_buffer_checker #(
  parameter int PAGE_LSB = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register port
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // read port and flash
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic fl_rd_en,
  input wire logic [27:0] fl_line_addr,
  // programming, power and interrupt
  input wire logic prog_busy,
  input wire logic [31:0] prog_addr,
  input wire logic sleep_mode,
  input wire logic clk_enable,
  input wire logic sec_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ack_single: assert property (rd_ack |=> !rd_ack)
    else $error("read answer held past one cycle");
  a_ack_cause: assert property (rd_ack |-> $past(rd_req))
    else $error("read answer without a request");
  a_err_with_ack: assert property (rd_err |-> rd_ack)
    else $error("bus error outside an answer");
  a_flash_single: assert property (fl_rd_en |=> !fl_rd_en)
    else $error("flash starts overlap");
  a_demand_tag: assert property (fl_rd_en && rd_req && !rd_ack |->
    fl_line_addr == rd_addr[31:4]) else $error("demand fetch at wrong line");
  a_predict_next: assert property (rd_ack && fl_rd_en |->
    fl_line_addr == rd_addr[31:4] + 28'h1) else $error("prediction not next line");
  // only stalls held for four cycles in a row are judged, a running miss may still answer
  a_page_stall: assert property ((rd_req && prog_busy &&
    rd_addr[31:PAGE_LSB] == prog_addr[31:PAGE_LSB]) [*4] |=> !rd_ack)
    else $error("read of busy page answered");
  a_sleep_gate: assert property (sleep_mode |=> !clk_enable)
    else $error("clock kept in sleep");
  a_idle_finish: assert property (fl_rd_en && !sleep_mode |=> clk_enable)
    else $error("clock gated under a running access");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("register access not ready");
  a_apb_unmapped: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");

  c_bus_error: cover property (rd_ack && rd_err);
  c_predict: cover property (rd_ack && fl_rd_en);
  c_irq: cover property (sec_irq);
  c_gated: cover property (!clk_enable);
endmodule

bind flash_prefetch_line_buffer flash_prefetch_line_buffer_checker #(.PAGE_LSB(PAGE_LSB))
  checker_inst (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .rd_req,
  .rd_addr, .rd_ack, .rd_err, .fl_rd_en, .fl_line_addr, .prog_busy, .prog_addr,
  .sleep_mode, .clk_enable, .sec_irq);

// ---- verification/tb_flash_prefetch_line_buffer.sv ----
// self-checking bench for the flash prefetch line buffer
`timescale 1ns/100ps
module tb_flash_prefetch_line_buffer;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_data, a, d, rd_addr = 32'h0, prog_addr = 32'h0;
  logic pready, pslverr, rd_ack, rd_err, fl_rd_en, fl_sec, fl_ded, clk_enable, sec_irq, e, p;
  logic rd_req = 1'h0, prog_event = 1'h0, prog_busy = 1'h0, idle_mode = 1'h0;
  logic sleep_mode = 1'h0, err_sec = 1'h0, err_ded = 1'h0;
  logic [1:0] rd_type = 2'h0;
  logic [27:0] fl_line_addr, err_line = 28'h0;
  logic [127:0] fl_rdata;
  logic [2:0] ws = 3'h3;
  logic [2:0] wl[3] = '{3'h0, 3'h3, 3'h7};
  logic [1:0] ps[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [1:0] pt[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  int errors = 0, num_checks = 0, lat;

  always #5 pclk = ~pclk;

  flash_prefetch_line_buffer #(.PAGE_LSB(12)) flash_prefetch_line_buffer_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rd_req, .rd_addr, .rd_type, .rd_ack, .rd_data, .rd_err, .fl_rd_en, .fl_line_addr,
    .fl_rdata, .fl_sec, .fl_ded, .prog_event, .prog_busy, .prog_addr, .idle_mode,
    .sleep_mode, .clk_enable, .sec_irq);
  flash_array_model flash_array_model_inst (.pclk, .presetn, .fl_rd_en, .fl_line_addr,
    .fl_rdata, .fl_sec, .fl_ded, .ws, .err_line, .err_sec, .err_ded);

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic hang();
    errors++;
    $display("[ERR] t=%0t wait ran out got %h exp %h", $time, 1'h0, 1'h1);
    end_sim();
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic chk_lat(input int got, input int exp);
    chk_word(32'(got), 32'(exp));
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) hang();
    d = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic rdreg(input logic [11:0] ad, input logic [31:0] x);
    apb(1'h0, ad, 32'h0);
    chk_word(d, x);
  endtask

  task automatic cfg(input logic [2:0] w, input logic [1:0] s);
    ws <= w;
    apb(1'h1, 12'h000, {26'h0, s, 1'h0, w});
  endtask

  // lat counts edges from raising the request to seeing the answer
  task automatic rd(input logic [31:0] ad, input logic [1:0] t);
    rd_addr <= ad;
    rd_type <= t;
    rd_req <= 1'h1;
    lat = 0;
    do begin
      @(posedge pclk);
      lat++;
    end while (rd_ack !== 1'h1 && lat < 200);
    if (lat >= 200) hang();
    d = rd_data;
    e = rd_err;
    rd_req <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [31:0] ad, input logic [1:0] t, input int x);
    rd(ad, t);
    chk_word(d, {ad[31:4], ad[3:2], 2'h3});
    chk_lat(lat, x);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdreg(12'h000, flash_prefetch_pkg::CTRL_RESET);
    rdreg(12'h010, flash_prefetch_pkg::STAT_RESET);
    apb(1'h1, 12'h000, 32'hffff_ffff);
    rdreg(12'h000, flash_prefetch_pkg::CTRL_MASK);
    apb(1'h1, 12'h004, 32'h0400_0001);
    rdreg(12'h000, 32'h0000_0036);
    apb(1'h1, 12'h00c, 32'h0000_0030);
    rdreg(12'h000, 32'h0000_0006);
    apb(1'h1, 12'h008, 32'h0000_0010);
    rdreg(12'h000, 32'h0000_0016);
    apb(1'h0, 12'h020, 32'h0);
    chk_bit(e, 1'h1);
    $display("test registers done");
    foreach (wl[i]) begin
      cfg(wl[i], 2'h0);
      a = 32'h0001_0000 + {21'h0, wl[i], 8'h0};
      rdchk(a, 2'h0, int'(wl[i]) + 3);
      rdchk(a + 32'h4, 2'h2, 2);
      rdchk(a + 32'hc, 2'h1, 2);
    end
    $display("test wait states done");
    for (int i = 0; i < 6; i++) begin
      cfg(3'h2, ps[i]);
      a = 32'h0002_0000 + (32'(i) << 8);
      rdchk(a, pt[i], 5);
      repeat (12) @(posedge pclk);
      p = ps[i] == 2'h3 || (ps[i] == 2'h2 && pt[i] != 2'h2) || (ps[i] == 2'h1 && pt[i] == 2'h0);
      rdchk(a + 32'h10, pt[i], p ? 2 : 5);
    end
    cfg(3'h7, 2'h1);
    rdchk(32'h0003_0000, 2'h0, 10);
    for (int k = 1; k < 8; k++) rdchk(32'h0003_0000 + 32'(4 * k), 2'h0, 2);
    rdchk(32'h0004_0000, 2'h0, 10);
    rd(32'h0005_0000, 2'h0);
    chk_bit(lat > 10, 1'h1);
    $display("test prediction done");
    cfg(3'h1, 2'h0);
    apb(1'h1, 12'h010, 32'h1);
    err_line <= 28'h0006000;
    err_sec <= 1'h1;
    rdchk(32'h0006_0000, 2'h0, 4);
    rdreg(12'h010, 32'h0);
    rdchk(32'h0006_0004, 2'h0, 2);
    rdreg(12'h010, 32'h0);
    err_line <= 28'h0006001;
    rdchk(32'h0006_0010, 2'h0, 4);
    rdreg(12'h010, 32'h0400_0000);
    apb(1'h1, 12'h008, 32'h0400_0000);
    @(posedge pclk);
    chk_bit(sec_irq, 1'h1);
    apb(1'h1, 12'h014, 32'h0400_0000);
    @(posedge pclk);
    chk_bit(sec_irq, 1'h0);
    apb(1'h1, 12'h018, 32'h0400_0000);
    @(posedge pclk);
    chk_bit(sec_irq, 1'h1);
    cfg(3'h1, 2'h1);
    apb(1'h1, 12'h010, 32'h5);
    err_line <= 28'h000a001;
    rdchk(32'h000a_0000, 2'h0, 4);
    repeat (8) @(posedge pclk);
    rdreg(12'h010, 32'h5);
    rdchk(32'h000a_0010, 2'h0, 2);
    rdreg(12'h010, 32'h4);
    cfg(3'h1, 2'h0);
    err_sec <= 1'h0;
    err_ded <= 1'h1;
    err_line <= 28'h0007000;
    rd(32'h0007_0000, 2'h0);
    chk_bit(e, 1'h1);
    rd(32'h0007_0008, 2'h0);
    chk_lat(lat, 2);
    chk_bit(e, 1'h1);
    rdreg(12'h010, 32'h0800_0004);
    err_ded <= 1'h0;
    apb(1'h1, 12'h010, 32'h0);
    apb(1'h1, 12'h018, 32'h0800_0000);
    rdreg(12'h010, 32'h0);
    $display("test error reporting done");
    rdchk(32'h0008_0000, 2'h0, 4);
    prog_event <= 1'h1;
    @(posedge pclk);
    prog_event <= 1'h0;
    repeat (3) @(posedge pclk);
    rdchk(32'h0008_0004, 2'h0, 4);
    prog_addr <= 32'h0009_0000;
    prog_busy <= 1'h1;
    fork
      rd(32'h0009_0004, 2'h0);
      begin
        repeat (30) @(posedge pclk);
        prog_busy <= 1'h0;
      end
    join
    chk_bit(lat > 30, 1'h1);
    $display("test coherency done");
    sleep_mode <= 1'h1;
    repeat (2) @(posedge pclk);
    chk_bit(clk_enable, 1'h0);
    sleep_mode <= 1'h0;
    idle_mode <= 1'h1;
    repeat (3) @(posedge pclk);
    chk_bit(clk_enable, 1'h0);
    idle_mode <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h0;
    ws <= 3'h3;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdchk(32'h0008_0008, 2'h0, 6);
    $display("test power and reset done");
    end_sim();
  end
endmodule
